// *** hex_segment_encoder.v ***
/*
 One hexadecimal digit to seven segments, active high, bit order g f e d c b a.
 Assumes the caller registers its output; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module hex_segment_encoder
(
	// Digit value
	input wire [3:0] nibble_in,
	// Segment pattern
	output reg [6:0] segments_out
);

	// Table lookup; b and d drawn in lower case so they differ from 8 and 0
	always @*
	begin
		case (nibble_in)
			4'h0: segments_out = 7'h3F;
			4'h1: segments_out = 7'h06;
			4'h2: segments_out = 7'h5B;
			4'h3: segments_out = 7'h4F;
			4'h4: segments_out = 7'h66;
			4'h5: segments_out = 7'h6D;
			4'h6: segments_out = 7'h7D;
			4'h7: segments_out = 7'h07;
			4'h8: segments_out = 7'h7F;
			4'h9: segments_out = 7'h6F;
			4'hA: segments_out = 7'h77; // (RULE15)
			4'hB: segments_out = 7'h7C; // (RULE15)
			4'hC: segments_out = 7'h39; // (RULE15)
			4'hD: segments_out = 7'h5E; // (RULE15)
			4'hE: segments_out = 7'h79; // (RULE15)
			default: segments_out = 7'h71;
		endcase
	end

endmodule // hex_segment_encoder
`default_nettype wire

// *** operator_keypad.sv ***
/* Operator keypad model: presses one key at a time.
 Assumes the display samples the keys on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module operator_keypad
(
	// Clock
	input wire clock_in,
	// Keys: select, back, up, down
	output var logic [3:0] keys_out
);
	initial keys_out = 4'h0;
	// Held six cycles so the synchroniser and edge detect see it; then six idle
	task automatic press(input int k);
		keys_out[k] <= 1'b1;
		repeat (6) @(posedge clock_in);
		keys_out[k] <= 1'b0;
		repeat (6) @(posedge clock_in);
	endtask
endmodule // operator_keypad
`default_nettype wire

// *** running_status_hex_display.v ***
/*
 Running status word assembly, I/O check menu selection and four-digit hex display,
 with an Avalon-MM slave for control and readback.
 Assumes state flags and terminal samples come from logic on clock_in; the menu scope
 value is written by software over the bus. Segment outputs are registered with the shown
 word, so the pins change once per update and never show a half-decoded glyph.
*/
// Function
// (RULE1) Twelve status flags at fixed bit positions of a sixteen-bit word
// (RULE2) Bit 15 set during parameter write
// (RULE3) Bits 14, 13, 6, 4 always zero
// (RULE4) Bit 12 set when link control enabled
// (RULE5) Bit 11 set on alarm
// (RULE6) Bit 10 decelerating, bit 9 accelerating
// (RULE7) Bit 8 during current limiting
// (RULE8) Bit 7 during voltage limiting
// (RULE9) Bit 5 when bus above undervoltage
// (RULE10) Bit 3 when output stage stopped
// (RULE11) Bit 2 during DC braking
// (RULE12) Bit 1 during reverse run
// (RULE13) Bit 0 during forward run
// (RULE14) High nibble leftmost, low nibble rightmost
// (RULE15) Hex digits, lower-case b and d
// (RULE16) Operator sets full-menu scope first
// (RULE17) Select enters list; key returns upward
// (RULE18) Item 0 shows terminal I/O word
// (RULE19) Item 1 shows link-commanded I/O word
// (RULE20) Items 2-4 show analog readings
// (RULE21) Status word is a monitor item
`timescale 1ns/1ps
`default_nettype none
`include "status_display_map.vh"

module running_status_hex_display
#(
	parameter DIGITS = 4
)
(
	// Clock and reset
	input wire clock_in,
	input wire rst_in,
	// Drive state flags, same clock domain
	input wire param_write_busy_in,
	input wire link_control_ready_in,
	input wire fault_flag_in,
	input wire decel_flag_in,
	input wire accel_flag_in,
	input wire current_limit_active_in,
	input wire voltage_limit_active_in,
	input wire bus_above_undervolt_in,
	input wire output_stopped_in,
	input wire dc_brake_active_in,
	input wire reverse_run_in,
	input wire forward_run_in,
	// Terminal samples, same clock domain
	input wire [15:0] terminal_io_word_in,
	input wire [15:0] link_io_word_in,
	input wire [15:0] analog_voltage_input_in,
	input wire [15:0] analog_current_input_in,
	input wire [15:0] meter_voltage_output_in,
	// Operator keys, asynchronous pins
	input wire key_select_in,
	input wire key_back_in,
	input wire key_up_in,
	input wire key_down_in,
	// Avalon-MM slave
	input wire [3:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	output reg [31:0] avs_readdata_out,
	output wire avs_waitrequest_out,
	// Display
	output reg [15:0] display_word_out,
	output wire [7*DIGITS-1:0] segments_out,
	output reg [2:0] display_view_out,
	output reg [2:0] check_item_out
);

	// One-hot menu states
	localparam ST_MENU = 3'b001;
	localparam ST_LIST = 3'b010;
	localparam ST_ITEM = 3'b100;
	// Highest I/O check item code
	localparam [2:0] ITEM_LAST = 3'h4;

	reg [31:0] ctrl_q; // Software control word
	reg [15:0] status_q; // Registered running status word
	reg [2:0] state_q; // Menu position
	reg [2:0] item_q; // Selected check item
	reg [3:0] key_meta_q; // First synchroniser stage
	reg [3:0] key_sync_q; // Second synchroniser stage
	reg [3:0] key_prev_q; // Previous synchronised level for edges
	reg ack_q; // Bus answer phase
	wire [3:0] key_rise;
	wire full_menu;
	wire request;
	reg [15:0] status_d;
	reg [15:0] shown_d;
	reg [15:0] display_d; // Word for the digits after blanking
	wire [7*DIGITS-1:0] seg_d; // Glyphs decoded from display_d
	reg [7*DIGITS-1:0] seg_q; // Registered glyphs driving the pins

	// Decode an aligned word offset into a read value
	function [31:0] read_mux;
		input [3:0] addr;
		input [31:0] ctrl;
		input [15:0] stat;
		input [15:0] shown;
		input [2:0] st;
		input [2:0] item;
		begin
			case (addr)
				`REG_CTRL: read_mux = ctrl;
				`REG_FLAGS: read_mux = {24'h000000, 2'h0, st, item};
				`REG_STATUS: read_mux = {16'h0000, stat};
				`REG_IOWORD: read_mux = {16'h0000, shown};
				default: read_mux = `READ_UNMAPPED;
			endcase
		end
	endfunction

	// Every access answers in its second cycle; read data is captured at the end of the first, writes land at the end of the second
	assign request = (avs_read_in | avs_write_in) & ~ack_q;
	assign avs_waitrequest_out = request;
	assign full_menu = (ctrl_q[`CTRL_SCOPE_MSB:`CTRL_SCOPE_LSB] == `SCOPE_FULL); // (RULE16)

	// Bus answer phase and control register writes
	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ack_q <= 1'b0;
			ctrl_q <= `CTRL_RESET;
			avs_readdata_out <= 32'h00000000;
		end
		else
		begin
			// A master holding read past its answer starts a fresh access; data stands until then
			ack_q <= request;
			if (request && avs_read_in)
				avs_readdata_out <= read_mux(avs_address_in, ctrl_q, status_q, display_word_out, state_q, item_q);
			// Write lands on the edge that sees waitrequest low
			if (ack_q && avs_write_in && avs_address_in == `REG_CTRL)
			begin
				if (avs_byteenable_in[0])
					ctrl_q[7:0] <= avs_writedata_in[7:0];
				if (avs_byteenable_in[1])
					ctrl_q[15:8] <= avs_writedata_in[15:8];
			end
		end
	end

	// Key synchronisers; edge detect reads the second stage and its delayed copy, never the first stage
	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			key_meta_q <= 4'h0;
			key_sync_q <= 4'h0;
			key_prev_q <= 4'h0;
		end
		else
		begin
			key_meta_q <= {key_down_in, key_up_in, key_back_in, key_select_in};
			key_sync_q <= key_meta_q;
			key_prev_q <= key_sync_q;
		end
	end
	assign key_rise = key_sync_q & ~key_prev_q;

	// Status word assembly; unused positions stay zero
	always @*
	begin
		status_d = 16'h0000; // (RULE3)
		status_d[`ST_BUSY] = param_write_busy_in; // (RULE2)
		status_d[`ST_LINK] = link_control_ready_in; // (RULE4)
		status_d[`ST_FAULT] = fault_flag_in; // (RULE5)
		status_d[`ST_DECEL] = decel_flag_in; // (RULE6)
		status_d[`ST_ACCEL] = accel_flag_in; // (RULE6)
		status_d[`ST_ILIM] = current_limit_active_in; // (RULE7)
		status_d[`ST_VLIM] = voltage_limit_active_in; // (RULE8)
		status_d[`ST_NUV] = bus_above_undervolt_in; // (RULE9)
		status_d[`ST_STOP] = output_stopped_in; // (RULE10)
		status_d[`ST_DCBRK] = dc_brake_active_in; // (RULE11)
		status_d[`ST_REV] = reverse_run_in; // (RULE12)
		status_d[`ST_FWD] = forward_run_in; // (RULE13)
	end

	// Menu walk: select descends from menu and list, back climbs, select also climbs from an item, up/down step items
	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_q <= ST_MENU;
			item_q <= 3'h0;
		end
		else if (!full_menu)
		begin
			// Menu closed while scope is limited
			state_q <= ST_MENU;
		end
		else
		begin
			case (state_q)
				ST_MENU:
				begin
					if (key_rise[0])
						state_q <= ST_LIST; // (RULE17)
				end
				ST_LIST:
				begin
					if (key_rise[0])
						state_q <= ST_ITEM; // (RULE17)
					else if (key_rise[1])
						state_q <= ST_MENU; // (RULE17)
					else if (key_rise[2])
						item_q <= (item_q == ITEM_LAST) ? 3'h0 : item_q + 3'h1;
					else if (key_rise[3])
						item_q <= (item_q == 3'h0) ? ITEM_LAST : item_q - 3'h1;
				end
				ST_ITEM:
				begin
					if (key_rise[0] | key_rise[1])
						state_q <= ST_LIST; // (RULE17)
				end
				default:
					state_q <= ST_MENU;
			endcase
		end
	end

	// Word chosen for the digits
	always @*
	begin
		shown_d = status_d; // (RULE21)
		if (full_menu && state_q == ST_ITEM)
		begin
			case (item_q)
				3'h0: shown_d = terminal_io_word_in; // (RULE18)
				3'h1: shown_d = link_io_word_in; // (RULE19)
				3'h2: shown_d = analog_voltage_input_in; // (RULE20)
				3'h3: shown_d = analog_current_input_in; // (RULE20)
				default: shown_d = meter_voltage_output_in; // (RULE20)
			endcase
		end
		else if (full_menu && state_q == ST_LIST)
			shown_d = {12'h400, 1'b0, item_q}; // Item code 400n
	end

	// Blanking shows zeros rather than dark digits, so every glyph stays a legal hex digit
	always @*
	begin
		display_d = shown_d;
		if (ctrl_q[`CTRL_BLANK_BIT])
			display_d = 16'h0000;
	end

	// Registered display data, glyphs and view flags; word and glyphs always agree
	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			status_q <= 16'h0000;
			display_word_out <= 16'h0000;
			seg_q <= {DIGITS{`SEG_ZERO}};
			display_view_out <= `VIEW_STATUS;
			check_item_out <= 3'h0;
		end
		else
		begin
			status_q <= status_d; // (RULE1)
			display_word_out <= display_d;
			seg_q <= seg_d; // (RULE14)
			check_item_out <= item_q;
			if (!full_menu)
				display_view_out <= `VIEW_STATUS;
			else if (state_q == ST_ITEM)
				display_view_out <= `VIEW_ITEM;
			else if (state_q == ST_LIST)
				display_view_out <= `VIEW_LIST;
			else
				display_view_out <= `VIEW_MENU;
		end
	end

	// One encoder per digit; digit DIGITS-1 is leftmost and carries the top nibble.
	// The encoders see the next word, so glyphs land on the same edge as the word.
	genvar g;
	generate
		for (g = 0; g < DIGITS; g = g + 1)
		begin : digit
			hex_segment_encoder enc
			(
				.nibble_in(display_d[4*g+3:4*g]), // (RULE14)
				.segments_out(seg_d[7*g+6:7*g])
			);
		end
	endgenerate
	assign segments_out = seg_q;

endmodule // running_status_hex_display
`default_nettype wire

// *** status_display_checker_assertions.sv ***
/* Concurrent checks on the running status display ports.
 Assumes a bind into the display top; one clock, async active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module status_display_checker
#(
	parameter DIGITS = 4
)
(
	// Clock, reset and drive flags
	input wire clock_in, rst_in, param_write_busy_in, link_control_ready_in, fault_flag_in,
	input wire decel_flag_in, accel_flag_in, current_limit_active_in, voltage_limit_active_in,
	input wire bus_above_undervolt_in, output_stopped_in, dc_brake_active_in, reverse_run_in, forward_run_in,
	// Bus handshake and display
	input wire avs_read_in, avs_write_in, avs_waitrequest_out,
	input wire [15:0] display_word_out,
	input wire [7*DIGITS-1:0] segments_out,
	input wire [2:0] display_view_out, check_item_out
);
	// Word the flags ask for; bits 14, 13, 6, 4 stay low
	wire [15:0] st = {param_write_busy_in, 2'b00, link_control_ready_in, fault_flag_in, decel_flag_in,
		accel_flag_in, current_limit_active_in, voltage_limit_active_in, 1'b0, bus_above_undervolt_in, 1'b0,
		output_stopped_in, dc_brake_active_in, reverse_run_in, forward_run_in};
	// Status and menu views both carry the status word
	wire on_st = display_view_out < 3'h2;
	// Glyphs F..0, one byte each, lower-case b and d
	localparam [127:0] SEG = 128'h71795E397C776F7F077D6D664F5B063F;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	a_whole_word: assert property (on_st && $past(on_st) |-> display_word_out == $past(st))
		else $error("status word differs from flags");
	a_busy_bit: assert property (on_st && $past(on_st) |-> display_word_out[15] == $past(param_write_busy_in))
		else $error("busy bit wrong");
	a_zero_bits: assert property (on_st |->
		{display_word_out[14:13], display_word_out[6], display_word_out[4]} == 4'h0)
		else $error("reserved bit set");
	a_link_fault: assert property (on_st && $past(on_st) |->
		display_word_out[12:11] == $past(st[12:11]))
		else $error("link or fault bit wrong");
	a_ramp_limit: assert property (on_st && $past(on_st) |->
		display_word_out[10:7] == $past(st[10:7]))
		else $error("ramp or limit bits wrong");
	a_low_bits: assert property (on_st && $past(on_st) |->
		display_word_out[5:0] == $past(st[5:0]))
		else $error("low status bits wrong");
	a_seg_right: assert property (segments_out[6:0] == SEG[display_word_out[3:0]*8 +: 7])
		else $error("rightmost digit glyph wrong");
	a_seg_left: assert property (segments_out[27:21] == SEG[display_word_out[15:12]*8 +: 7])
		else $error("leftmost digit glyph wrong");
	a_list_code: assert property (display_view_out == 3'h2 |->
		display_word_out == (16'h4000 | check_item_out))
		else $error("list code wrong");
	// One wait state per access
	a_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("wait state too long");
	c_list: cover property (display_view_out == 3'h2);
	c_item: cover property (display_view_out == 3'h3);
	c_busy: cover property (on_st && display_word_out[15]);
endmodule // status_display_checker
`default_nettype wire

// *** status_display_map.vh ***
/*
 Offsets, field positions, reset values and menu codes for the running status display.
 Assumes it is included by bare name from the design files of the display block.
*/
`ifndef STATUS_DISPLAY_MAP_VH
`define STATUS_DISPLAY_MAP_VH

// Avalon register offsets (byte addresses, one word each)
`define REG_CTRL 4'h0
`define REG_FLAGS 4'h4
`define REG_STATUS 4'h8
`define REG_IOWORD 4'hC

// Control register fields
`define CTRL_VIEW_LSB 0
`define CTRL_VIEW_MSB 2
`define CTRL_SCOPE_LSB 4
`define CTRL_SCOPE_MSB 5
`define CTRL_BLANK_BIT 8

// Status word bit positions
`define ST_BUSY 15
`define ST_LINK 12
`define ST_FAULT 11
`define ST_DECEL 10
`define ST_ACCEL 9
`define ST_ILIM 8
`define ST_VLIM 7
`define ST_NUV 5
`define ST_STOP 3
`define ST_DCBRK 2
`define ST_REV 1
`define ST_FWD 0

// Display view codes driven on display_view_out
`define VIEW_STATUS 3'h0
`define VIEW_MENU 3'h1
`define VIEW_LIST 3'h2
`define VIEW_ITEM 3'h3

// Menu scope value that opens the full menus
`define SCOPE_FULL 2'h2

// Reset and unmapped read values
`define CTRL_RESET 32'h00000000
`define READ_UNMAPPED 32'h00000000
// Glyph for zero, shown on every digit while in reset
`define SEG_ZERO 7'h3F

`endif

// *** tb.sv ***
/* Self-checking bench for the running status display.
 Assumes the display top, the checker and the keypad model are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0;
	logic [11:0] fl = 0; // Drive flags, busy at the top
	logic [15:0] io [5] = '{default: 16'h0}; // Terminal, link and analog samples
	logic [15:0] r = 16'h59C6; // LFSR state, seed 22982
	logic [15:0] e; // Expected status word
	logic [3:0] be = 4'hF; // Byte lanes of the bus master
	localparam logic [127:0] GLYPHS = 128'h71795E397C776F7F077D6D664F5B063F; // Digits F..0, one byte each
	logic [3:0] avs_address_in = 0;
	logic [31:0] avs_writedata_in = 0, q;
	wire [31:0] avs_readdata_out;
	wire avs_waitrequest_out;
	wire [15:0] display_word_out;
	wire [27:0] segments_out;
	wire [2:0] display_view_out, check_item_out;
	wire [3:0] keys;
	int n_fail = 0, n_tests = 0;
	always #12.5 clock_in = ~clock_in;
	operator_keypad i_pad (.clock_in(clock_in), .keys_out(keys));
	running_status_hex_display i_dut (.clock_in(clock_in), .rst_in(rst_in),
		.param_write_busy_in(fl[11]), .link_control_ready_in(fl[10]), .fault_flag_in(fl[9]),
		.decel_flag_in(fl[8]), .accel_flag_in(fl[7]), .current_limit_active_in(fl[6]),
		.voltage_limit_active_in(fl[5]), .bus_above_undervolt_in(fl[4]), .output_stopped_in(fl[3]),
		.dc_brake_active_in(fl[2]), .reverse_run_in(fl[1]), .forward_run_in(fl[0]),
		.terminal_io_word_in(io[0]), .link_io_word_in(io[1]), .analog_voltage_input_in(io[2]),
		.analog_current_input_in(io[3]), .meter_voltage_output_in(io[4]),
		.key_select_in(keys[0]), .key_back_in(keys[1]), .key_up_in(keys[2]), .key_down_in(keys[3]),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(be), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .display_word_out(display_word_out),
		.segments_out(segments_out), .display_view_out(display_view_out), .check_item_out(check_item_out));
	function automatic logic [15:0] lf(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [15:0] exp_st(input logic [11:0] f);
		return {f[11], 2'b00, f[10:5], 1'b0, f[4], 1'b0, f[3:0]};
	endfunction
	task automatic chk(input logic [31:0] seen, exp, input string what);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Holds the request until waitrequest is sampled low at a rising edge; the watchdog ends a hang
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
		@(posedge clock_in);
		{avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} <= {!w, w, a, d};
		do
			@(posedge clock_in);
		while (avs_waitrequest_out !== 1'b0);
		rd = avs_readdata_out;
		{avs_read_in, avs_write_in} <= 2'b00;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clock_in);
		rst_in <= 0;
		// Random flags with all-ones and all-zeros corners
		for (int i = 0; i < 24; i++)
		begin
			r = lf(r);
			fl <= (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : r[11:0];
			repeat (3) @(posedge clock_in);
			bus(0, 4'h8, 0, q);
			e = exp_st(fl);
			chk(q[31:16], 16'h0, "status upper");
			chk(q[15:12], e[15:12], "status busy link");
			chk(q[11:7], e[11:7], "status alarm ramp limit");
			chk(q[6:0], e[6:0], "status low bits");
			chk(display_word_out, e, "shown word");
			for (int d = 0; d < 4; d++)
				chk(segments_out[7*d +: 7], GLYPHS[8*e[4*d +: 4] +: 7], "digit glyph");
			io[i % 5] <= r ^ 16'h5A5A;
		end
		$display("status word test done");
		bus(0, 4'h2, 0, q);
		chk(q, 32'h0, "unmapped read");
		bus(1, 4'h8, 32'hFFFF, q);
		bus(0, 4'h8, 0, q);
		chk(q, {16'h0, exp_st(fl)}, "status read only");
		// Keys do nothing until the full menu scope is set
		i_pad.press(0);
		chk(display_view_out, 3'h0, "menu locked");
		// Only the low lane is enabled: the blank bit in lane 1 must stay clear
		be <= 4'h1;
		bus(1, 4'h0, 32'hFFFFFF20, q);
		be <= 4'hF;
		bus(0, 4'h0, 0, q);
		chk(q, 32'h20, "ctrl readback");
		i_pad.press(0);
		chk(display_view_out, 3'h2, "list view");
		// Walk every item, leaving by select and back in turn
		for (int i = 0; i < 5; i++)
		begin
			chk(display_word_out, 16'h4000 | i, "item code");
			i_pad.press(0);
			chk(display_word_out, io[i], "item value");
			i_pad.press(i % 2);
			chk(display_view_out, 3'h2, "back to list");
			i_pad.press(2);
		end
		chk(check_item_out, 3'h0, "item wrap up");
		i_pad.press(3);
		chk(check_item_out, 3'h4, "item wrap down");
		// Blank and unblank while an item is shown, where no status check watches the word
		i_pad.press(0);
		bus(1, 4'h0, 32'h120, q);
		bus(0, 4'hC, 0, q);
		chk(q, 32'h0, "blanked word");
		bus(1, 4'h0, 32'h20, q);
		bus(0, 4'hC, 0, q);
		chk(q, {16'h0, io[4]}, "shown word reg");
		i_pad.press(1);
		i_pad.press(1);
		chk(display_view_out, 3'h1, "back to menu");
		bus(0, 4'h4, 0, q);
		chk(q, 32'h0C, "menu flags");
		$display("menu test done");
		tally_and_finish();
	end
	// Whole run needs a few hundred cycles; 8000 is ample
	initial
	begin
		#200us;
		n_fail++;
		tally_and_finish();
	end
endmodule // tb
bind running_status_hex_display status_display_checker #(.DIGITS(DIGITS)) i_chk (.*);
`default_nettype wire
